/* File: sas_analog_model.sv */
// Purpose: Comparator and analog levels behind the converter.
// Assumes: A level is the code that the input voltage equals.
// Notes:   Powered down, the comparator always reports below.
`timescale 1ns/1ps
module sas_analog_model (
  input  wire logic [15:0][7:0] levels,
  input  wire logic [3:0]       channel_select,
  input  wire logic [7:0]       dac_code,
  input  wire logic             converter_power_on,
  output logic                  comp_above
);
  // One of sixteen levels reaches the comparator.
  // A level of FF is at or above every trial code, 00 above none but 00.
  // Levels are analog only; nothing reads a pin digitally while sampling.
  assign comp_above = converter_power_on && (levels[channel_select] >= dac_code);
endmodule

/* File: sas_pkg.sv */
// Purpose: Shared constants and types for the converter sequencer.
// Assumes: One 50 MHz clock; E-clock and RC-clock ticks are enables.
// Notes:   Register offsets are local to the block's byte bus.
package sas_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [2:0] SAS_OFF_CTRL   = 3'h0;
  localparam logic [2:0] SAS_OFF_RES0   = 3'h1;
  localparam logic [2:0] SAS_OFF_RES3   = 3'h4;
  localparam logic [2:0] SAS_OFF_OPTION = 3'h5;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int SAS_CTRL_DONE  = 7;
  localparam int SAS_CTRL_SCAN  = 5;
  localparam int SAS_CTRL_MULTI_CHANNEL_SEL  = 4;
  localparam logic [7:0] SAS_CTRL_WMASK = 8'h3F;

  // ---------------------------------------------------------------
  // Options register fields
  // ---------------------------------------------------------------
  localparam int SAS_OPT_POWER = 7;
  localparam int SAS_OPT_CONV_CLOCK_SOURCE_SEL  = 6;
  localparam int SAS_OPT_DLY   = 4;
  localparam logic [7:0] SAS_OPT_RESET   = 8'h10;
  localparam logic [7:0] SAS_OPT_FREE    = 8'hC0;
  localparam logic [7:0] SAS_OPT_PROT    = 8'h3B;
  localparam logic [7:0] SAS_OPT_RDMASK  = 8'hFB;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SAS_PROT_WINDOW = 64;
  localparam int SAS_SAMPLE_CYC  = 12;
  localparam int SAS_BITS        = 8;
  localparam int SAS_STOP_LONG   = 4000;
  localparam int SAS_STOP_SHORT  = 4;
  localparam int SAS_SETTLE_US   = 100;
  localparam int SAS_CLK_MHZ     = 50;
  localparam int SAS_SETTLE_CYC  = SAS_SETTLE_US * SAS_CLK_MHZ;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } sas_bus_req_t;

  typedef enum logic [1:0] {
    SAS_IDLE,
    SAS_SAMPLE,
    SAS_CONVERT
  } sas_state_t;

endpackage

/* File: sas_sar_step.sv */
// Purpose: One successive-approximation conversion of eight bits.
// Assumes: Comparator result is valid when a tick arrives.
// Notes:   Trial bit walks from the top bit down.
`timescale 1ns/1ps
module sas_sar_step (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       start,
  input  wire logic       tick,
  input  wire logic       comp_above,
  output logic [7:0]      approximation_register,
  output logic [7:0]      trial_code,
  output logic            done
);
  import sas_pkg::*;

  logic [7:0] sar_q;
  logic [7:0] sar_d;
  logic [7:0] bit_q;
  logic [7:0] bit_d;
  logic       done_d;

  // ---------------------------------------------------------------
  // Approximation steps
  // ---------------------------------------------------------------
  always_comb begin
    sar_d  = sar_q;
    bit_d  = bit_q;
    done_d = 1'b0;
    if (start) begin
      sar_d = 8'h00;
      bit_d = 8'h80;
    end else if (tick && (bit_q != 8'h00)) begin
      // Kept bit follows the comparator, so low reference gives 00, high gives FF.
      if (comp_above) begin
        sar_d = sar_q | bit_q;
      end
      bit_d  = bit_q >> 1;
      done_d = (bit_q == 8'h01);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sar_q <= 8'h00;
      bit_q <= 8'h00;
      done  <= 1'b0;
      trial_code <= 8'h00;
    end else begin
      sar_q <= sar_d;
      bit_q <= bit_d;
      done  <= done_d;
      trial_code <= sar_d | bit_d;
    end
  end

  // Taken from the register, so the value holds steady once the last step is done.
  assign approximation_register = sar_q;

endmodule

/* File: sas_sequencer.sv */
// Purpose: Control, sequencing and result storage for an 8-bit converter.
// Assumes: Bus inputs are synchronous; e_tick and rc_tick are 1-cycle enables.
// Notes:   The analog array is outside; this block drives mux select and DAC code.
//
// Functional notes
// - Exactly one of sixteen inputs is routed, by four select bits.
// - Each conversion runs eight compare steps from the top bit.
// - A finished conversion copies the approximation into its slot's result.
// - Four eight-bit readable result registers hold converted values.
// - Results update only in cycles with no processor read.
// - Conversions run in groups of four, once or repeating.
// - The done flag sets when the fourth conversion completes.
// - A sequence starts one E-clock tick after the control write.
// - The sample switch is closed for a window of twelve conversion-clock ticks only.
// - Low reference gives 00, high gives FF, no overflow flag.
// - Options bit 7 powers the converter and its charge pump.
// - Clock source bit picks E clock at 0, RC clock at 1.
// - Stop exit waits about 4000 E cycles when delay bit set, else four.
// - Protected option bits take one write within 64 cycles unless special mode.
// - Options bit 2 is not implemented and reads zero.
// - Single pass halts after four; continuous wraps results to the first.
// - Multi-channel converts the group chosen by the upper two select bits.
// - Any control write clears done and restarts, aborting any sequence.
// - Codes 0-7 are pins, three (12-14) are internal points, five (8-11 and 15) are reserved.
`timescale 1ns/1ps
module sas_sequencer (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire sas_pkg::sas_bus_req_t bus_req,
  output logic [7:0]                 bus_rdata,
  input  wire logic                  special_mode,
  input  wire logic                  e_tick,
  input  wire logic                  rc_tick,
  input  wire logic                  comp_above,
  input  wire logic                  stop_exit_req,
  output logic [3:0]                 channel_select,
  output logic                       channel_reserved,
  output logic                       sample_switch_on,
  output logic [7:0]                 dac_code,
  output logic                       converter_power_on,
  output logic                       charge_pump_en,
  output logic                       conv_clock_source_sel,
  output logic                       stop_exit_delay_en,
  output logic                       stop_exit_done
);
  import sas_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] ctrl_q, ctrl_d;
  logic       sequence_done_flag_q, sequence_done_flag_d;
  logic [7:0] option_q, option_d;
  logic       prot_used_q, prot_used_d;
  logic [6:0] rst_cnt_q, rst_cnt_d;
  logic [7:0] result_q [4];
  logic [7:0] result_d [4];
  logic [7:0] result_reg_first;
  sas_state_t state_q, state_d;
  logic [1:0] slot_q, slot_d;
  logic [3:0] samp_q, samp_d;
  logic       pend_q, pend_d;
  logic       pend_res_q, pend_res_d;
  logic [7:0] pend_val_q, pend_val_d;
  logic [1:0] pend_slot_q, pend_slot_d;
  logic [11:0] stop_cnt_q, stop_cnt_d;
  logic       stop_busy_q, stop_busy_d;
  logic       stop_done_d;

  logic       conv_tick;
  logic       sar_start;
  logic       sar_done;
  logic [7:0] sar_value;
  logic [7:0] trial;
  logic       wr_ctrl;
  logic       multi_channel_sel;
  logic       scan_en;

  assign wr_ctrl           = bus_req.wr && (bus_req.addr == SAS_OFF_CTRL);
  assign multi_channel_sel = ctrl_q[SAS_CTRL_MULTI_CHANNEL_SEL];
  assign scan_en           = ctrl_q[SAS_CTRL_SCAN];
  assign conv_tick         = option_q[SAS_OPT_CONV_CLOCK_SOURCE_SEL] ? rc_tick : e_tick;
  assign result_reg_first  = result_q[0];

  sas_sar_step u_sar (
    .clk                    (clk),
    .arst_n                 (arst_n),
    .start                  (sar_start),
    .tick                   (conv_tick && (state_q == SAS_CONVERT)),
    .comp_above             (comp_above),
    .approximation_register (sar_value),
    .trial_code             (trial),
    .done                   (sar_done)
  );

  // ---------------------------------------------------------------
  // Options register
  // ---------------------------------------------------------------
  always_comb begin
    option_d    = option_q;
    prot_used_d = prot_used_q;
    rst_cnt_d   = rst_cnt_q;
    if (rst_cnt_q != 7'(SAS_PROT_WINDOW)) begin
      rst_cnt_d = rst_cnt_q + 7'h01;
    end
    if (bus_req.wr && (bus_req.addr == SAS_OFF_OPTION)) begin
      option_d = (option_q & ~SAS_OPT_FREE) | (bus_req.wdata & SAS_OPT_FREE);
      if (special_mode || (!prot_used_q && (rst_cnt_q < 7'(SAS_PROT_WINDOW)))) begin
        option_d = (option_d & ~SAS_OPT_PROT) | (bus_req.wdata & SAS_OPT_PROT);
        prot_used_d = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Stop exit delay
  // ---------------------------------------------------------------
  always_comb begin
    stop_cnt_d  = stop_cnt_q;
    stop_busy_d = stop_busy_q;
    stop_done_d = 1'b0;
    if (stop_exit_req && !stop_busy_q) begin
      stop_busy_d = 1'b1;
      stop_cnt_d  = option_q[SAS_OPT_DLY] ? 12'(SAS_STOP_LONG) : 12'(SAS_STOP_SHORT);
    end else if (stop_busy_q && e_tick) begin
      if (stop_cnt_q <= 12'h001) begin
        stop_busy_d = 1'b0;
        stop_done_d = 1'b1;
      end else begin
        stop_cnt_d = stop_cnt_q - 12'h001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_d               = ctrl_q;
    sequence_done_flag_d = sequence_done_flag_q;
    state_d              = state_q;
    slot_d               = slot_q;
    samp_d               = samp_q;
    pend_d               = pend_q;
    pend_res_d           = pend_res_q;
    pend_val_d           = pend_val_q;
    pend_slot_d          = pend_slot_q;
    sar_start            = 1'b0;
    for (int i = 0; i < 4; i++) begin
      result_d[i] = result_q[i];
    end
    // A result waits while the processor reads, so a read never sees a half update.
    if (pend_res_q && !bus_req.rd) begin
      result_d[pend_slot_q] = pend_val_q;
      pend_res_d = 1'b0;
    end
    if (!option_q[SAS_OPT_POWER]) begin
      state_d = SAS_IDLE;
    end else begin
      case (state_q)
        SAS_IDLE: begin
          if (pend_q && e_tick) begin
            pend_d  = 1'b0;
            slot_d  = 2'h0;
            samp_d  = 4'h0;
            state_d = SAS_SAMPLE;
          end
        end
        SAS_SAMPLE: begin
          if (conv_tick) begin
            if (samp_q == 4'(SAS_SAMPLE_CYC - 1)) begin
              state_d   = SAS_CONVERT;
              sar_start = 1'b1;
            end else begin
              samp_d = samp_q + 4'h1;
            end
          end
        end
        SAS_CONVERT: begin
          if (sar_done) begin
            pend_res_d  = 1'b1;
            pend_val_d  = sar_value;
            pend_slot_d = slot_q;
            slot_d      = slot_q + 2'h1;
            samp_d      = 4'h0;
            if (slot_q == 2'h3) begin
              sequence_done_flag_d = 1'b1;
              state_d = scan_en ? SAS_SAMPLE : SAS_IDLE;
            end else begin
              state_d = SAS_SAMPLE;
            end
          end
        end
        default: state_d = SAS_IDLE;
      endcase
    end
    if (wr_ctrl) begin
      ctrl_d               = bus_req.wdata & SAS_CTRL_WMASK;
      sequence_done_flag_d = 1'b0;
      pend_d               = 1'b1;
      state_d              = SAS_IDLE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q               <= 8'h00;
      sequence_done_flag_q <= 1'b0;
      option_q             <= SAS_OPT_RESET;
      prot_used_q          <= 1'b0;
      rst_cnt_q            <= 7'h00;
      state_q              <= SAS_IDLE;
      slot_q               <= 2'h0;
      samp_q               <= 4'h0;
      pend_q               <= 1'b0;
      pend_res_q           <= 1'b0;
      pend_val_q           <= 8'h00;
      pend_slot_q          <= 2'h0;
      stop_cnt_q           <= 12'h000;
      stop_busy_q          <= 1'b0;
      stop_exit_done       <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        result_q[i] <= 8'h00;
      end
    end else begin
      ctrl_q               <= ctrl_d;
      sequence_done_flag_q <= sequence_done_flag_d;
      option_q             <= option_d;
      prot_used_q          <= prot_used_d;
      rst_cnt_q            <= rst_cnt_d;
      state_q              <= state_d;
      slot_q               <= slot_d;
      samp_q               <= samp_d;
      pend_q               <= pend_d;
      pend_res_q           <= pend_res_d;
      pend_val_q           <= pend_val_d;
      pend_slot_q          <= pend_slot_d;
      stop_cnt_q           <= stop_cnt_d;
      stop_busy_q          <= stop_busy_d;
      stop_exit_done       <= stop_done_d;
      for (int i = 0; i < 4; i++) begin
        result_q[i] <= result_d[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs and read data
  // ---------------------------------------------------------------
  always_comb begin
    channel_select = ctrl_q[3:0];
    if (multi_channel_sel) begin
      channel_select = {ctrl_q[3:2], slot_q};
    end
  end

  assign channel_reserved      = (channel_select[3:2] == 2'b10) || (channel_select == 4'hF);
  assign sample_switch_on      = (state_q == SAS_SAMPLE);
  assign dac_code              = trial;
  assign converter_power_on    = option_q[SAS_OPT_POWER];
  assign charge_pump_en        = option_q[SAS_OPT_POWER];
  assign conv_clock_source_sel = option_q[SAS_OPT_CONV_CLOCK_SOURCE_SEL];
  assign stop_exit_delay_en    = option_q[SAS_OPT_DLY];

  always_comb begin
    bus_rdata = 8'h00;
    case (bus_req.addr)
      SAS_OFF_CTRL:   bus_rdata = {sequence_done_flag_q, 1'b0, ctrl_q[5:0]};
      SAS_OFF_OPTION: bus_rdata = option_q & SAS_OPT_RDMASK;
      SAS_OFF_RES0:   bus_rdata = result_reg_first;
      SAS_OFF_RES0 + 3'h1: bus_rdata = result_q[1];
      SAS_OFF_RES0 + 3'h2: bus_rdata = result_q[2];
      SAS_OFF_RES3:   bus_rdata = result_q[3];
      default:        bus_rdata = 8'h00;
    endcase
  end

endmodule

/* File: sas_sequencer_assertions.sv */
// Purpose: Port checks for the converter sequencer.
// Assumes: Conversion ticks follow the selected clock source.
// Notes:   The stop bound suits a bench with one E tick per four clocks.
`timescale 1ns/1ps
module sas_sequencer_assertions (
  input wire logic         clk,
  input wire logic         arst_n,
  input wire sas_pkg::sas_bus_req_t bus_req,
  input wire logic [7:0]   bus_rdata,
  input wire logic         e_tick,
  input wire logic         rc_tick,
  input wire logic         stop_exit_req,
  input wire logic [3:0]   channel_select,
  input wire logic         channel_reserved,
  input wire logic         sample_switch_on,
  input wire logic         converter_power_on,
  input wire logic         charge_pump_en,
  input wire logic         conv_clock_source_sel,
  input wire logic         stop_exit_delay_en,
  input wire logic         stop_exit_done
);
  import sas_pkg::*;

  // -------------------------------------------------------------
  // Sample window tick counter
  // -------------------------------------------------------------
  logic       tick;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  assign tick = conv_clock_source_sel ? rc_tick : e_tick;
  always_comb begin
    cnt_d = sample_switch_on ? cnt_q + {4'h0, tick} : 5'h00;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_chan_reserved: assert property (channel_reserved ==
    (channel_select[3:2] == 2'b10 || channel_select == 4'hF)) else $error("reserved flag wrong");
  a_pump_power: assert property (charge_pump_en == converter_power_on)
    else $error("charge pump differs from power");
  a_opt_bit2: assert property (bus_req.addr == SAS_OFF_OPTION |-> !bus_rdata[2])
    else $error("options bit 2 not zero");
  a_opt_write: assert property ($past(bus_req.wr && bus_req.addr == SAS_OFF_OPTION)
    |-> {converter_power_on, conv_clock_source_sel} == $past(bus_req.wdata[7:6]))
    else $error("power or clock source missed a write");
  a_done_clear: assert property ($past(bus_req.wr && bus_req.addr == SAS_OFF_CTRL)
    && bus_req.addr == SAS_OFF_CTRL |-> !bus_rdata[SAS_CTRL_DONE])
    else $error("done flag not cleared by write");
  a_result_hold: assert property (bus_req.rd && $past(bus_req.rd) && $stable(bus_req.addr)
    && bus_req.addr inside {[SAS_OFF_RES0:SAS_OFF_RES3]} |-> $stable(bus_rdata))
    else $error("result changed during read");
  a_sample_len: assert property ($fell(sample_switch_on) && converter_power_on
    && !$past(bus_req.wr) |-> cnt_q == 5'h0C) else $error("sample window not twelve ticks");
  a_off_idle: assert property (!converter_power_on && !$past(converter_power_on)
    |-> !sample_switch_on) else $error("sampling while powered down");
  a_stop_short: assert property (stop_exit_req && !stop_exit_delay_en
    |-> ##[1:40] stop_exit_done) else $error("short stop exit too slow");
endmodule
bind sas_sequencer sas_sequencer_assertions i_chk (.clk, .arst_n, .bus_req, .bus_rdata,
  .e_tick, .rc_tick, .stop_exit_req, .channel_select, .channel_reserved, .sample_switch_on,
  .converter_power_on, .charge_pump_en, .conv_clock_source_sel, .stop_exit_delay_en,
  .stop_exit_done);

/* File: sas_sequencer_bench.sv */
// Purpose: Register-level tests of the converter sequencer.
// Assumes: E tick every four clocks, RC tick every three.
// Notes:   Results are compared with the levels the analog model holds.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module sas_sequencer_bench;
  import sas_pkg::*;
  logic             clk = 1'b0;
  logic             arst_n = 1'b0;
  sas_bus_req_t     bus_req = '0;
  logic             special_mode = 1'b0, stop_exit_req = 1'b0;
  logic             e_tick = 1'b0, rc_tick = 1'b0, comp_above;
  logic [1:0]       ec = 2'h0, rc = 2'h0;
  logic [7:0]       bus_rdata, dac_code, d, r;
  logic [3:0]       channel_select;
  logic             channel_reserved, sample_switch_on, converter_power_on, charge_pump_en;
  logic             conv_clock_source_sel, stop_exit_delay_en, stop_exit_done;
  logic [15:0][7:0] lv = {8'h33, 8'h80, 8'h00, 8'hFF, 8'hC4, 8'h9B, 8'h27, 8'h61,
                          8'h10, 8'h20, 8'h30, 8'h40, 8'hE7, 8'h01, 8'h7E, 8'h5A};
  int               n_errors = 0, num_checks = 0, n;
  sas_sequencer i_dut (.clk, .arst_n, .bus_req, .bus_rdata, .special_mode, .e_tick,
    .rc_tick, .comp_above, .stop_exit_req, .channel_select, .channel_reserved,
    .sample_switch_on, .dac_code, .converter_power_on, .charge_pump_en,
    .conv_clock_source_sel, .stop_exit_delay_en, .stop_exit_done);
  sas_analog_model i_ana (.levels(lv), .channel_select, .dac_code, .converter_power_on,
    .comp_above);
  always #10 clk = ~clk;
  always @(posedge clk) begin
    ec <= ec + 2'h1;
    e_tick <= (ec == 2'h3);
    rc <= (rc == 2'h2) ? 2'h0 : rc + 2'h1;
    rc_tick <= (rc == 2'h2);
  end
  // -------------------------------------------------------------
  // Bus and sequence tasks
  // -------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge clk);
    v = bus_rdata;
    bus_req.rd <= 1'b0;
  endtask
  task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
    rd_reg(a, d);
    `CHK(d, e)
  endtask
  task automatic run_seq(input logic [7:0] c, input logic [3:0][7:0] e);
    wr_reg(SAS_OFF_CTRL, c);
    d = 8'h00;
    for (int i = 0; i < 600 && d[SAS_CTRL_DONE] !== 1'b1; i++) begin
      rd_reg(SAS_OFF_CTRL, d);
    end
    if (d[SAS_CTRL_DONE] !== 1'b1) begin
      n_errors++;
      end_sim();
    end
    for (int i = 0; i < 4; i++) begin
      chk_rd(3'(SAS_OFF_RES0 + i), e[i]);
    end
  endtask
  task automatic stop_run(output int k);
    @(posedge clk);
    stop_exit_req <= 1'b1;
    @(posedge clk);
    stop_exit_req <= 1'b0;
    k = 0;
    for (int i = 0; i < 20000; i++) begin
      @(posedge clk);
      if (stop_exit_done === 1'b1) return;
      if (e_tick === 1'b1) k++;
    end
    k = 99999;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    chk_rd(SAS_OFF_OPTION, 8'h10);
    wr_reg(SAS_OFF_OPTION, 8'hFF);
    chk_rd(SAS_OFF_OPTION, 8'hFB);
    wr_reg(SAS_OFF_OPTION, 8'h80);
    chk_rd(SAS_OFF_OPTION, 8'hBB);
    `CHK(converter_power_on, 1'b1)
    repeat (SAS_SETTLE_CYC) @(posedge clk);
    $display("end of test 1");
    run_seq(8'h03, {4{lv[3]}});
    `CHK(channel_select, 4'h3)
    $display("end of test 2");
    wr_reg(SAS_OFF_CTRL, 8'h03);
    repeat (60) @(posedge clk);
    run_seq(8'h17, lv[7:4]);
    $display("end of test 3");
    wr_reg(SAS_OFF_OPTION, 8'hC0);
    @(posedge clk);
    `CHK(conv_clock_source_sel, 1'b1)
    run_seq(8'h1C, lv[15:12]);
    $display("end of test 4");
    wr_reg(SAS_OFF_OPTION, 8'h80); // E clock is fast enough here.
    run_seq(8'h30, lv[3:0]);
    @(posedge clk);
    bus_req.rd <= 1'b1;
    bus_req.addr <= SAS_OFF_RES0;
    lv[0] <= 8'hA5;
    repeat (400) @(posedge clk);
    bus_req.rd <= 1'b0;
    for (int i = 0; i < 300 && d !== 8'hA5; i++) begin
      rd_reg(SAS_OFF_RES0, d);
    end
    `CHK(d, 8'hA5)
    $display("end of test 5");
    special_mode <= 1'b1;
    wr_reg(SAS_OFF_OPTION, 8'h00);
    chk_rd(SAS_OFF_OPTION, 8'h00);
    `CHK(converter_power_on, 1'b0)
    rd_reg(SAS_OFF_RES0, r);
    wr_reg(SAS_OFF_CTRL, 8'h03);
    repeat (500) @(posedge clk);
    chk_rd(SAS_OFF_CTRL, 8'h03);
    chk_rd(SAS_OFF_RES0, r);
    $display("end of test 6");
    stop_run(n);
    `CHK(n <= SAS_STOP_SHORT + 1, 1'b1)
    $display("end of test 7");
    @(posedge clk);
    arst_n <= 1'b0;
    special_mode <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (70) @(posedge clk);
    wr_reg(SAS_OFF_OPTION, 8'h80);
    chk_rd(SAS_OFF_OPTION, 8'h90);
    stop_run(n);
    `CHK(n >= SAS_STOP_LONG - 4 && n <= SAS_STOP_LONG + 4, 1'b1)
    $display("end of test 8");
    end_sim();
  end
endmodule
